// [rtl/sfci_top.v]
// Serial command interface of a page-organised flash with two page buffers.
// Assumes pins arrive asynchronously to CLK; the host keeps its own timing duties.
`timescale 1ns/1ps
`default_nettype none
`include "sfci_defs.vh"

// Behaviour
// - Strict form: output bit changes right at the detected SCK falling edge.
// - Fast form: output bit appears one clock later, still mode 0 or 3.
// - Page to buffer copy finishes within the transfer time.
// - Erase-and-program holds busy for the erase-and-program time.
// - Protection starts one microsecond after guard pin low, lifts when high.
// - Every field moves as bytes of exactly eight SCK cycles.
// - Opcode E8 streams the array continuously across pages.
// - Opcode D2 reads one main page, wrapping inside it, buffers untouched.
// - Opcodes D4 and D6 read buffer one or two from the given byte.
// - Opcode D7 returns status bytes right after the opcode.
// - Opcode 9F returns identification bytes right after the opcode.
// - Address field is reserved bit, page bits, then byte bits.
module sfci_top #(
   parameter        PW        = 13,
   parameter [31:0] XFR_CYC   = `SFCI_XFR_CYC,
   parameter [31:0] EP_CYC    = `SFCI_EP_CYC,
   parameter [31:0] P_CYC     = `SFCI_P_CYC,
   parameter [16:0] PROT_MASK = 17'h1FFFF,
   parameter [7:0]  MFR_ID    = 8'h5A,  // Arbitrary value
   parameter [7:0]  DEV_ID1   = 8'h3C,  // Arbitrary value
   parameter [7:0]  DEV_ID2   = 8'h01,  // Arbitrary value
   parameter [3:0]  DENSITY   = 4'hD
) (
   input  wire CLK,
   input  wire SYS_RST,
   input  wire CLK_EN,
   input  wire CS_N,
   input  wire SCK,
   input  wire SI,
   input  wire RESET_N,
   input  wire WP_N,
   input  wire FAST_SERIAL_FORM,
   output reg  SO,
   output reg  SO_OE_N,
   output reg  RDY_BUSY,
   output reg  PROT_ACTIVE
);
   localparam AW     = PW + 11;
   localparam E_IDLE = 2'h0;
   localparam E_RD   = 2'h1;
   localparam E_WR   = 2'h2;
   localparam E_WAIT = 2'h3;

   reg  [5:0]    s1_q, s2_q;
   reg           sck_q, cs_q, ld_q, out_en_q, bit_q;
   reg  [2:0]    bit_cnt_q;
   reg  [3:0]    byte_cnt_q;
   reg  [7:0]    sh_q, op_q, tx_q;
   reg  [23:0]   adr_q;
   reg  [12:0]   pg_q, eng_pg_q;
   reg  [9:0]    ptr_q, eng_i_q;
   reg  [1:0]    id_i_q, eng_st_q;
   reg           eng_prog_q, eng_sel_q;
   reg  [31:0]   wait_q;
   reg  [8:0]    wp_cnt_q;
   reg           m_en, m_we;
   reg  [AW-1:0] m_addr;
   reg  [7:0]    m_wd;
   wire [7:0]    m_rd;

   wire cs_n_s  = s2_q[0];
   wire sck_s   = s2_q[1];
   wire si_s    = s2_q[2];
   wire rstn_s  = s2_q[3];
   wire wpn_s   = s2_q[4];
   wire fast_s  = s2_q[5];
   wire cs_act  = ~cs_n_s & rstn_s;
   wire rise    = cs_act & sck_s & ~sck_q;
   wire fall    = cs_act & ~sck_s & sck_q;
   wire cs_end  = cs_q & ~cs_act & rstn_s;
   wire busy    = (eng_st_q != E_IDLE);
   wire [7:0] rxb    = {sh_q[6:0], si_s};
   wire       wrap   = rise & (bit_cnt_q == 3'h7);
   wire [7:0] op_now = (byte_cnt_q == 4'h0) ? rxb : op_q;
   wire [3:0] hdr    = hdr_len(op_now);
   wire [3:0] nb     = (byte_cnt_q == 4'hF) ? 4'hF : byte_cnt_q + 4'h1;
   wire       fetch  = wrap & (hdr != 4'h0) & (nb >= hdr);
   wire       info   = (op_now == `SFCI_OP_STAT_RD) || (op_now == `SFCI_OP_ID_RD);
   wire       mfetch = fetch & ~info;
   wire       wr_buf = wrap & is_fill(op_q) & (byte_cnt_q >= `SFCI_ADDR_BYTES);
   wire       is_main = (op_q == `SFCI_OP_CONT_RD) || (op_q == `SFCI_OP_PAGE_RD);
   wire       buf_sel = op_sel(op_q);
   wire [23:0] adr_full = {adr_q[15:0], rxb};
   wire [4:0]  sector   = sector_of(pg_q);
   wire        blocked  = PROT_ACTIVE & PROT_MASK[sector];
   wire [7:0]  status   = {~busy, 1'b0, DENSITY, PROT_ACTIVE, 1'b0};

   function [3:0] hdr_len(input [7:0] op);
      case (op)
         `SFCI_OP_CONT_RD, `SFCI_OP_PAGE_RD: hdr_len = `SFCI_HDR_LONG;
         `SFCI_OP_BUF1_RD, `SFCI_OP_BUF2_RD: hdr_len = `SFCI_HDR_BUF;
         `SFCI_OP_STAT_RD, `SFCI_OP_ID_RD:   hdr_len = `SFCI_HDR_SHORT;
         default:                            hdr_len = 4'h0;
      endcase
   endfunction

   function is_fill(input [7:0] op);
      is_fill = (op == `SFCI_OP_BUF1_WR) || (op == `SFCI_OP_BUF2_WR) ||
                (op == `SFCI_OP_PROG1_WR) || (op == `SFCI_OP_PROG2_WR);
   endfunction

   function op_sel(input [7:0] op);
      op_sel = (op == `SFCI_OP_BUF2_RD) || (op == `SFCI_OP_BUF2_WR) || (op == `SFCI_OP_PROG2_WR) ||
               (op == `SFCI_OP_B2PG_ER) || (op == `SFCI_OP_B2PG) || (op == `SFCI_OP_PG_B2);
   endfunction

   function [4:0] sector_of(input [12:0] pg);
      if (pg[12:3] == 10'h000) begin
         sector_of = 5'h00;
      end else if (pg[12:9] == 4'h0) begin
         sector_of = 5'h01;
      end else begin
         sector_of = {1'b0, pg[12:9]} + 5'h01;
      end
   endfunction

   function [AW-1:0] maddr(input main, input sel, input [12:0] pg, input [9:0] b);
      if (main) begin
         maddr = {1'b1, pg[PW-1:0], b};
      end else begin
         maddr = {{PW{1'b0}}, sel, b};
      end
   endfunction

   function [9:0] next_ptr(input [9:0] p);
      next_ptr = (p >= `SFCI_PAGE_LAST) ? 10'h000 : p + 10'h001;
   endfunction

   // Input synchronisers, two flops per pin
   always @(posedge CLK) begin
      if (SYS_RST) begin
         s1_q <= `SFCI_SYNC_RST;
         s2_q <= `SFCI_SYNC_RST;
      end else if (CLK_EN) begin
         s1_q <= {FAST_SERIAL_FORM, WP_N, RESET_N, SI, SCK, CS_N};
         s2_q <= s1_q;
      end
   end

   // Memory port: serial side while selected, copy engine otherwise
   always @* begin
      m_en   = 1'b0;
      m_we   = 1'b0;
      m_addr = {AW{1'b0}};
      m_wd   = rxb;
      if (mfetch | wr_buf) begin
         m_en   = 1'b1;
         m_we   = wr_buf;
         m_addr = maddr(is_main, buf_sel, pg_q, ptr_q);
      end else if (!cs_act && (eng_st_q == E_RD)) begin
         m_en   = 1'b1;
         m_addr = maddr(~eng_prog_q, eng_sel_q, eng_pg_q, eng_i_q);
      end else if (!cs_act && (eng_st_q == E_WR)) begin
         m_en   = 1'b1;
         m_we   = 1'b1;
         m_wd   = m_rd;
         m_addr = maddr(eng_prog_q, eng_sel_q, eng_pg_q, eng_i_q);
      end
   end

   sfci_mem #(.AW(AW)) u_mem (
      .clk     (CLK),
      .ce      (CLK_EN),
      .en      (m_en),
      .we      (m_we),
      .addr    (m_addr),
      .wdata   (m_wd),
      .rdata_q (m_rd)
   );

   // Serial receive, address capture and output shifting
   always @(posedge CLK) begin
      if (SYS_RST) begin
         sck_q <= 1'b0; cs_q <= 1'b0; ld_q <= 1'b0; out_en_q <= 1'b0; bit_q <= 1'b0;
         bit_cnt_q <= 3'h0; byte_cnt_q <= 4'h0; sh_q <= 8'h00; op_q <= 8'h00; tx_q <= 8'h00;
         adr_q <= 24'h000000; pg_q <= 13'h0000; ptr_q <= 10'h000; id_i_q <= 2'h0;
         SO <= 1'b0; SO_OE_N <= 1'b1;
      end else if (CLK_EN) begin
         sck_q <= sck_s;
         cs_q  <= cs_act;
         ld_q  <= mfetch;
         if (ld_q) begin
            tx_q <= m_rd;
         end
         if (!cs_act) begin
            bit_cnt_q  <= 3'h0;
            byte_cnt_q <= 4'h0;
            out_en_q   <= 1'b0;
            id_i_q     <= 2'h0;
            SO_OE_N    <= 1'b1;
         end else begin
            if (rise) begin
               sh_q      <= rxb;
               bit_cnt_q <= bit_cnt_q + 3'h1;
            end
            if (wrap) begin
               byte_cnt_q <= nb;
               if (byte_cnt_q == 4'h0) begin
                  op_q <= rxb;
               end
               if (byte_cnt_q != 4'h0 && byte_cnt_q < `SFCI_ADDR_BYTES) begin
                  adr_q <= adr_full;
               end
               if (byte_cnt_q == 4'h3) begin
                  pg_q  <= adr_full[22:10];
                  ptr_q <= adr_full[9:0];
               end
            end
            if (mfetch | wr_buf) begin
               ptr_q <= next_ptr(ptr_q);
               if (op_q == `SFCI_OP_CONT_RD && ptr_q >= `SFCI_PAGE_LAST) begin
                  pg_q <= pg_q + 13'h0001;
               end
            end
            if (fetch) begin
               out_en_q <= 1'b1;
               if (op_now == `SFCI_OP_STAT_RD) begin
                  tx_q <= status;
               end else if (op_now == `SFCI_OP_ID_RD) begin
                  id_i_q <= (id_i_q == 2'h3) ? 2'h3 : id_i_q + 2'h1;
                  case (id_i_q)
                     2'h0:    tx_q <= MFR_ID;
                     2'h1:    tx_q <= DEV_ID1;
                     2'h2:    tx_q <= DEV_ID2;
                     default: tx_q <= 8'h00;
                  endcase
               end
            end
            if (fall && out_en_q) begin
               bit_q   <= tx_q[3'h7 - bit_cnt_q];
               SO_OE_N <= 1'b0;
            end
         end
         if (fast_s) begin
            SO <= bit_q;
         end else if (fall && out_en_q) begin
            SO <= tx_q[3'h7 - bit_cnt_q];
         end
      end
   end

   // Internal copy engine and busy timer
   always @(posedge CLK) begin
      if (SYS_RST) begin
         eng_st_q <= E_IDLE; eng_prog_q <= 1'b0; eng_sel_q <= 1'b0;
         eng_pg_q <= 13'h0000; eng_i_q <= 10'h000; wait_q <= 32'h00000000;
         RDY_BUSY <= 1'b1;
      end else if (CLK_EN) begin
         RDY_BUSY <= ~busy;
         if (wait_q != 32'h00000000) begin
            wait_q <= wait_q - 32'h00000001;
         end
         if (!rstn_s) begin
            eng_st_q <= E_IDLE;
            wait_q   <= 32'h00000000;
         end else begin
            case (eng_st_q)
               E_IDLE: begin
                  if (cs_end && byte_cnt_q >= `SFCI_ADDR_BYTES) begin
                     eng_sel_q <= buf_sel;
                     eng_pg_q  <= pg_q;
                     eng_i_q   <= 10'h000;
                     case (op_q)
                        `SFCI_OP_PG_B1, `SFCI_OP_PG_B2: begin
                           eng_prog_q <= 1'b0;
                           wait_q     <= XFR_CYC;
                           eng_st_q   <= E_RD;
                        end
                        `SFCI_OP_B1PG_ER, `SFCI_OP_B2PG_ER, `SFCI_OP_PROG1_WR, `SFCI_OP_PROG2_WR: begin
                           if (!blocked) begin
                              eng_prog_q <= 1'b1;
                              wait_q     <= EP_CYC;
                              eng_st_q   <= E_RD;
                           end
                        end
                        `SFCI_OP_B1PG, `SFCI_OP_B2PG: begin
                           if (!blocked) begin
                              eng_prog_q <= 1'b1;
                              wait_q     <= P_CYC;
                              eng_st_q   <= E_RD;
                           end
                        end
                        default: eng_st_q <= E_IDLE;
                     endcase
                  end
               end
               E_RD: begin
                  if (!cs_act) begin
                     eng_st_q <= E_WR;
                  end
               end
               E_WR: begin
                  if (!cs_act) begin
                     eng_i_q  <= eng_i_q + 10'h001;
                     eng_st_q <= (eng_i_q == `SFCI_PAGE_LAST) ? E_WAIT : E_RD;
                  end else begin
                     eng_st_q <= E_RD;
                  end
               end
               E_WAIT: begin
                  if (wait_q <= 32'h00000001) begin
                     eng_st_q <= E_IDLE;
                  end
               end
               default: eng_st_q <= E_IDLE;
            endcase
         end
      end
   end

   // Write guard: protection after the guard delay, lifted at once
   always @(posedge CLK) begin
      if (SYS_RST) begin
         wp_cnt_q    <= 9'h000;
         PROT_ACTIVE <= 1'b0;
      end else if (CLK_EN) begin
         if (wpn_s) begin
            wp_cnt_q    <= 9'h000;
            PROT_ACTIVE <= 1'b0;
         end else if (wp_cnt_q >= `SFCI_WPE_CYC - 1) begin
            PROT_ACTIVE <= 1'b1;
         end else begin
            wp_cnt_q <= wp_cnt_q + 9'h001;
         end
      end
   end
endmodule // sfci_top

`default_nettype wire

// [rtl/sfci_defs.vh]
// Constants of the serial flash command interface: opcodes, field layout, timing.
// Assumes a 250 MHz core clock; included by the interface only, not by its memory.
`ifndef SFCI_DEFS_VH
`define SFCI_DEFS_VH

`define SFCI_CLK_MHZ      250
`define SFCI_T_XFR_US     250
`define SFCI_T_EP_MS      20
`define SFCI_T_P_MS       14
`define SFCI_T_WPE_US     1
`define SFCI_XFR_CYC      (`SFCI_T_XFR_US * `SFCI_CLK_MHZ)
`define SFCI_EP_CYC       (`SFCI_T_EP_MS * 1000 * `SFCI_CLK_MHZ)
`define SFCI_P_CYC        (`SFCI_T_P_MS * 1000 * `SFCI_CLK_MHZ)
`define SFCI_WPE_CYC      (`SFCI_T_WPE_US * `SFCI_CLK_MHZ)

`define SFCI_PAGE_LAST    10'h20F
`define SFCI_BYTE_BITS    8
`define SFCI_ADDR_BYTES   4'h4
`define SFCI_SYNC_RST     6'h19

`define SFCI_OP_CONT_RD   8'hE8
`define SFCI_OP_PAGE_RD   8'hD2
`define SFCI_OP_BUF1_RD   8'hD4
`define SFCI_OP_BUF2_RD   8'hD6
`define SFCI_OP_STAT_RD   8'hD7
`define SFCI_OP_ID_RD     8'h9F
`define SFCI_OP_BUF1_WR   8'h84
`define SFCI_OP_BUF2_WR   8'h87
`define SFCI_OP_PROG1_WR  8'h82
`define SFCI_OP_PROG2_WR  8'h85
`define SFCI_OP_B1PG_ER   8'h83
`define SFCI_OP_B2PG_ER   8'h86
`define SFCI_OP_B1PG      8'h88
`define SFCI_OP_B2PG      8'h89
`define SFCI_OP_PG_B1     8'h53
`define SFCI_OP_PG_B2     8'h55

`define SFCI_HDR_LONG     4'h8
`define SFCI_HDR_BUF      4'h5
`define SFCI_HDR_SHORT    4'h1

`endif

// [rtl/sfci_mem.v]
// Single-port byte memory holding both page buffers and the main array.
// Assumes one access per cycle; read data come out of a register.
`timescale 1ns/1ps
`default_nettype none

module sfci_mem #(
   parameter AW = 24
) (
   input  wire          clk,
   input  wire          ce,
   input  wire          en,
   input  wire          we,
   input  wire [AW-1:0] addr,
   input  wire [7:0]    wdata,
   output reg  [7:0]    rdata_q
);
   reg [7:0] mem [0:(1<<AW)-1];

   always @(posedge clk) begin
      if (ce && en) begin
         if (we) begin
            mem[addr] <= wdata;
         end
         rdata_q <= mem[addr];
      end
   end
endmodule // sfci_mem

`default_nettype wire

// [verification/sfci_top_assertions.sv]
// Checker of the serial flash command interface, watching the top module ports only.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module sfci_check #(
   parameter [31:0] EP_CYC = 32'h0
) (
   input wire logic CLK,
   input wire logic SYS_RST,
   input wire logic CLK_EN,
   input wire logic CS_N,
   input wire logic SCK,
   input wire logic SI,
   input wire logic RESET_N,
   input wire logic WP_N,
   input wire logic FAST_SERIAL_FORM,
   input wire logic SO,
   input wire logic SO_OE_N,
   input wire logic RDY_BUSY,
   input wire logic PROT_ACTIVE
);
   logic [7:0]  wp_cnt_q;
   logic [31:0] busy_cnt_q;
   always_ff @(posedge CLK) begin
      if (SYS_RST || WP_N) wp_cnt_q <= 8'h00;
      else if (wp_cnt_q != 8'hFF) wp_cnt_q <= wp_cnt_q + 8'h01;
      if (SYS_RST || RDY_BUSY) busy_cnt_q <= 32'h0;
      else busy_cnt_q <= busy_cnt_q + 32'h1;
   end
   default clocking cb @(posedge CLK); endclocking
   default disable iff (SYS_RST);
   sequence so_moves;
      $changed(SO) && !SO_OE_N;
   endsequence
   sequence deselect;
      $rose(CS_N);
   endsequence
   sequence busy_begins;
      $fell(RDY_BUSY);
   endsequence
   so_strict_a: assert property (so_moves ##0 !FAST_SERIAL_FORM |-> !SCK)
      else $error("SO moved outside the low phase");
   so_fast_a: assert property (so_moves ##0 FAST_SERIAL_FORM |-> !SCK && !$past(SCK, 2))
      else $error("SO moved too early in fast form");
   oe_release_a: assert property (deselect |-> ##[1:5] SO_OE_N)
      else $error("SO still driven after deselect");
   busy_start_a: assert property (busy_begins |-> CS_N && $past(CS_N))
      else $error("Busy began while selected");
   busy_hold_a: assert property (busy_begins |-> !RDY_BUSY [*8])
      else $error("Busy pulse too short");
   busy_bound_a: assert property (busy_cnt_q <= EP_CYC + 32'd64)
      else $error("Busy lasted beyond the longest operation");
   prot_on_a: assert property ($rose(PROT_ACTIVE) |-> wp_cnt_q >= 8'd250)
      else $error("Protection came too soon after guard low");
   prot_off_a: assert property ($rose(WP_N) |-> ##[1:250] !PROT_ACTIVE)
      else $error("Protection did not lift in time");
   reset_abort_a: assert property (!RESET_N [*5] |-> SO_OE_N && RDY_BUSY)
      else $error("Device active while held in reset");
endmodule // sfci_check
bind sfci_top sfci_check #(.EP_CYC(EP_CYC)) u_check (
   .CLK(CLK), .SYS_RST(SYS_RST), .CLK_EN(CLK_EN), .CS_N(CS_N), .SCK(SCK), .SI(SI),
   .RESET_N(RESET_N), .WP_N(WP_N), .FAST_SERIAL_FORM(FAST_SERIAL_FORM), .SO(SO),
   .SO_OE_N(SO_OE_N), .RDY_BUSY(RDY_BUSY), .PROT_ACTIVE(PROT_ACTIVE));
`default_nettype wire

// [verification/sfci_host.sv]
// Host model: mode 0 serial controller driving select, clock and data in.
// Assumes a 16-cycle serial clock period (64 ns) on the core clock.
`timescale 1ns/1ps
`default_nettype none
module sfci_host (
   input  wire logic CLK,
   input  wire logic SO,
   output var  logic CS_N,
   output var  logic SCK,
   output var  logic SI,
   output var  logic RESET_N
);
   logic [7:0]  wbuf [0:3];
   logic [7:0]  rbuf [0:3];
   logic [12:0] rw_ptr = 13'h0001;
   initial begin
      CS_N    = 1'b1;
      SCK     = 1'b0;
      SI      = 1'b0;
      RESET_N = 1'b0;
   end
   task automatic release_reset();
      repeat (8) @(posedge CLK);
      RESET_N <= CS_N;
      repeat (8) @(posedge CLK);
   endtask
   task automatic pulse_reset();
      RESET_N <= 1'b0;
      release_reset();
   endtask
   function automatic logic [23:0] adr(input logic [12:0] pg, input logic [9:0] by);
      return {1'b0, pg, by};
   endfunction
   task automatic next_page(output logic [12:0] pg);
      pg = rw_ptr;
      rw_ptr = rw_ptr + 13'h0001;
   endtask
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         SI <= tx[i];
         repeat (7) @(posedge CLK);
         @(negedge CLK) rx[i] = SO;
         @(posedge CLK) SCK <= 1'b1;
         repeat (8) @(posedge CLK);
         SCK <= 1'b0;
      end
   endtask
   task automatic frame(input logic [7:0] op, input logic [23:0] ad, input int na, input int nd,
                        input int nw, input int nr);
      logic [7:0] d;
      repeat (64) @(posedge CLK);
      CS_N <= 1'b0;
      repeat (8) @(posedge CLK);
      xfer(op, d);
      for (int i = 0; i < na; i++) xfer(ad[23-8*i -: 8], d);
      for (int i = 0; i < nd; i++) xfer(8'h00, d);
      for (int i = 0; i < nw; i++) xfer(wbuf[i], d);
      for (int i = 0; i < nr; i++) begin
         xfer(8'h00, d);
         rbuf[i] = d;
      end
      repeat (8) @(posedge CLK);
      CS_N <= 1'b1;
      SI   <= ~SI;
   endtask
endmodule // sfci_host
`default_nettype wire

// [verification/sfci_top_tb.sv]
// Testbench of the serial flash command interface with the mode 0 host model.
// Assumes shortened busy counts and a four-page memory set at the instance.
`timescale 1ns/1ps
`default_nettype none
module sfci_top_tb;
   localparam [31:0] XFR = 32'd1200;
   localparam [31:0] EP  = 32'd1400;
   localparam [31:0] PRG = 32'd1300;
   logic        clk, sys_rst, wp_n, fast;
   wire         cs_n, sck, si, reset_n, so, so_oe_n, rdy_busy, prot_active;
   int          n_errors = 0;
   int          checked = 0;
   logic [12:0] pg;
   logic [7:0]  id [0:3] = '{8'h5A, 8'h3C, 8'h01, 8'h00};
   sfci_top #(.PW(2), .XFR_CYC(XFR), .EP_CYC(EP), .P_CYC(PRG)) dut (
      .CLK(clk), .SYS_RST(sys_rst), .CLK_EN(1'b1), .CS_N(cs_n), .SCK(sck), .SI(si),
      .RESET_N(reset_n), .WP_N(wp_n), .FAST_SERIAL_FORM(fast), .SO(so), .SO_OE_N(so_oe_n),
      .RDY_BUSY(rdy_busy), .PROT_ACTIVE(prot_active));
   sfci_host u_host (.CLK(clk), .SO(so), .CS_N(cs_n), .SCK(sck), .SI(si), .RESET_N(reset_n));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   function automatic logic [7:0] pat(input int b, input int i);
      return 8'hA0 + 8'(16 * b + i);
   endfunction
   task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic busy(input logic [31:0] cyc);
      int n;
      n = 0;
      while (rdy_busy !== 1'b0 && n < 40) begin
         @(negedge clk);
         n++;
      end
      n = 0;
      while (rdy_busy === 1'b0 && n < 5000) begin
         @(negedge clk);
         n++;
      end
      chk("busy length", 8'(n >= cyc - 8 && n <= cyc + 16), 8'h01);
      @(posedge clk);
   endtask
   task automatic t_status();
      for (int f = 0; f < 2; f++) begin
         @(posedge clk);
         fast <= f[0];
         u_host.frame(8'hD7, 24'h0, 0, 0, 0, 2);
         chk("status", u_host.rbuf[0], 8'hB4);
         chk("status again", u_host.rbuf[1], 8'hB4);
      end
      fast <= 1'b0;
   endtask
   task automatic t_id();
      u_host.frame(8'h9F, 24'h0, 0, 0, 0, 4);
      for (int i = 0; i < 4; i++) chk("ident", u_host.rbuf[i], id[i]);
   endtask
   task automatic t_buffers();
      for (int b = 0; b < 2; b++) begin
         for (int i = 0; i < 4; i++) u_host.wbuf[i] = pat(b, i);
         u_host.frame(b ? 8'h87 : 8'h84, u_host.adr(13'h0, 10'd526), 3, 0, 4, 0);
         u_host.frame(b ? 8'hD6 : 8'hD4, u_host.adr(13'h0, 10'd526), 3, 1, 0, 4);
         for (int i = 0; i < 4; i++) chk("buffer", u_host.rbuf[i], pat(b, i));
      end
   endtask
   task automatic t_program();
      u_host.next_page(pg);
      u_host.frame(8'h88, u_host.adr(pg, 10'd0), 3, 0, 0, 0);
      busy(PRG);
      u_host.frame(8'h86, u_host.adr(pg + 13'h1, 10'd0), 3, 0, 0, 0);
      busy(EP);
      u_host.frame(8'hD2, u_host.adr(pg, 10'd526), 3, 4, 0, 4);
      for (int i = 0; i < 4; i++) chk("page", u_host.rbuf[i], pat(0, i));
      u_host.frame(8'hE8, u_host.adr(pg, 10'd526), 3, 4, 0, 4);
      for (int i = 0; i < 4; i++) chk("array", u_host.rbuf[i], pat(i < 2 ? 0 : 1, i));
      u_host.frame(8'h55, u_host.adr(pg, 10'd0), 3, 0, 0, 0);
      busy(XFR);
      u_host.frame(8'hD6, u_host.adr(13'h0, 10'd526), 3, 1, 0, 4);
      for (int i = 0; i < 4; i++) chk("copied", u_host.rbuf[i], pat(0, i));
   endtask
   task automatic t_protect();
      @(posedge clk);
      wp_n <= 1'b0;
      repeat (240) @(posedge clk);
      chk("guard early", {7'h0, prot_active}, 8'h00);
      repeat (60) @(posedge clk);
      chk("guard on", {7'h0, prot_active}, 8'h01);
      u_host.frame(8'h88, u_host.adr(pg, 10'd0), 3, 0, 0, 0);
      repeat (40) @(negedge clk);
      chk("program refused", {7'h0, rdy_busy}, 8'h01);
      u_host.frame(8'hD7, 24'h0, 0, 0, 0, 1);
      chk("status guarded", u_host.rbuf[0], 8'hB6);
      wp_n <= 1'b1;
      repeat (250) @(posedge clk);
      chk("guard off", {7'h0, prot_active}, 8'h00);
   endtask
   task automatic t_abort();
      u_host.frame(8'h89, u_host.adr(pg, 10'd0), 3, 0, 0, 0);
      u_host.frame(8'hD7, 24'h0, 0, 0, 0, 1);
      chk("status busy", u_host.rbuf[0], 8'h34);
      chk("busy seen", {7'h0, rdy_busy}, 8'h00);
      u_host.pulse_reset();
      chk("abort ready", {7'h0, rdy_busy}, 8'h01);
      chk("abort released", {7'h0, so_oe_n}, 8'h01);
      u_host.frame(8'hD7, 24'h0, 0, 0, 0, 1);
      chk("status after abort", u_host.rbuf[0], 8'hB4);
   endtask
   task automatic final_report();
      $display("checks %0d errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      repeat (60000) @(posedge clk);
      n_errors++;
      final_report();
   end
   initial begin
      sys_rst = 1'b1;
      wp_n    = 1'b1;
      fast    = 1'b0;
      repeat (12) @(posedge clk);
      sys_rst <= 1'b0;
      u_host.release_reset();
      t_status();
      t_id();
      t_buffers();
      t_program();
      t_protect();
      t_abort();
      final_report();
   end
endmodule // sfci_top_tb
`default_nettype wire
